/* File: spz_sram_port.sv */
// Pipelined zero-turnaround static RAM port with burst counter and write log.
//
// What this block does
// - Write loaded at cycle n takes its data word from the bus two enabled edges later.
// - Burst write advances the counter; each data word follows its step by two cycles.
// - A new load ends the burst while the word still owed is transferred.
// - With clock enable high and reset low every input except output enable and log_ready is ignored and the output word holds.
// - Data latency counts enabled edges only, so suspended edges stretch it.
// - Back-to-back read loads give one word per cycle, two enabled edges behind.
// - A deselect right after a read load does not cancel that read.
// - A write loaded before deselect cycles still stores its data.
// - After reset the data outputs are high impedance from the first edge.
// - The read/write input is ignored while advancing; load value fixes direction.
// - The two-bit burst counter wraps after four words; order linear or interleaved.
`timescale 1ns/1ps
`include "spz_defs.svh"
module spz_sram_port
    import spz_pkg::*;
#(
    parameter int AW = `SPZ_ADDR_W,
    parameter int LOG_DEPTH = `SPZ_LOG_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [AW-1:0] address,
    input wire logic read_not_write,
    input wire logic advance_or_load,
    input wire logic select_low_a,
    input wire logic select_low_b,
    input wire logic select_high,
    input wire logic clock_enable_n,
    input wire logic [`SPZ_BYTES-1:0] byte_write_sel_n,
    input wire logic burst_order_sel,
    input wire logic out_enable_n,
    input wire logic [`SPZ_DATA_W-1:0] dq_in,
    output logic [`SPZ_DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic log_valid,
    input wire logic log_ready,
    output logic [AW+`SPZ_DATA_W-1:0] log_data,
    output logic log_space
);
    // ==========================================
    // State
    typedef struct packed {
        spz_mode_t mode;
        logic [AW-1:0] base;
        logic [`SPZ_BURST_W-1:0] cnt;
        spz_op_t p1;
        spz_op_t p2;
        logic [`SPZ_DATA_W-1:0] dout;
        logic oe;
    } spz_port_st_t;

    spz_port_st_t s_q;
    spz_port_st_t s_d;
    logic [`SPZ_DATA_W-1:0] mem_q [0:(2**AW)-1];
    logic en;
    logic sel;
    logic mem_we;
    spz_op_t op_n;
    logic [`SPZ_BURST_W-1:0] cnt_n;
    logic [`SPZ_DATA_W-1:0] wr_word;

    // Burst address order: interleaved when the order select is high, else linear.
    function automatic logic [`SPZ_BURST_W-1:0] burst_low(
        input logic [`SPZ_BURST_W-1:0] start,
        input logic [`SPZ_BURST_W-1:0] step,
        input logic interleave
    );
        if (interleave) begin
            return start ^ step;
        end
        return start + step;
    endfunction : burst_low

    // ==========================================
    // Decode
    // Only reset edges and edges with the clock enable low move the port state; the write log still drains.
    assign en = !clock_enable_n;
    assign sel = !select_low_a && !select_low_b && select_high;
    assign cnt_n = s_q.cnt + 1'b1;
    assign mem_we = en && s_q.p2.valid && s_q.p2.wr;

    // Next operation and burst state from the current control inputs.
    always_comb begin
        s_d = s_q;
        op_n = '0;
        if (!advance_or_load) begin
            // A load always ends the running burst; a deselect simply stops it.
            if (sel) begin
                op_n.valid = 1'b1;
                op_n.wr = !read_not_write;
                op_n.addr = address;
                op_n.bw_n = byte_write_sel_n;
                s_d.mode = read_not_write ? SPZ_READ : SPZ_WRITE;
                s_d.base = address;
            end else begin
                s_d.mode = SPZ_IDLE;
            end
            s_d.cnt = '0;
        end else if (s_q.mode != SPZ_IDLE) begin
            // Direction comes from the latched mode, not the read/write pin.
            op_n.valid = 1'b1;
            op_n.wr = (s_q.mode == SPZ_WRITE);
            op_n.addr = {s_q.base[AW-1:`SPZ_BURST_W],
                burst_low(s_q.base[`SPZ_BURST_W-1:0], cnt_n, burst_order_sel)};
            op_n.bw_n = byte_write_sel_n;
            s_d.cnt = cnt_n;
        end
        s_d.p1 = op_n;
        s_d.p2 = s_q.p1;
        // The stage leaving the pipe decides what the bus does next cycle.
        if (s_q.p2.valid && !s_q.p2.wr) begin
            s_d.dout = mem_q[s_q.p2.addr];
            s_d.oe = 1'b1;
        end else begin
            s_d.oe = 1'b0;
        end
        // A suspended edge keeps every register, the output word included.
        if (!en) begin
            s_d = s_q;
        end
    end

    // State register; reset releases the bus from the first edge.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Byte-lane merge: a lane takes the bus word only when its select is low.
    // One write process keeps the array single-driven.
    genvar gb;
    generate
        for (gb = 0; gb < `SPZ_BYTES; gb++) begin : g_lane
            assign wr_word[gb*`SPZ_BYTE_W +: `SPZ_BYTE_W] = s_q.p2.bw_n[gb] ?
                mem_q[s_q.p2.addr][gb*`SPZ_BYTE_W +: `SPZ_BYTE_W] :
                dq_in[gb*`SPZ_BYTE_W +: `SPZ_BYTE_W];
        end
    endgenerate

    // Array write port, one merged word per stored write.
    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            mem_q[s_q.p2.addr] <= wr_word;
        end
    end

    // Output enable acts without the clock and leaves the pipeline alone.
    assign dq_out = s_q.dout;
    assign dq_oe = s_q.oe && !out_enable_n;

    // ==========================================
    // Write log
    // Each stored write is logged with its bus word while log_space is high; a write made with the log full is not logged.
    spz_fifo #(
        .WIDTH(AW + `SPZ_DATA_W),
        .DEPTH(LOG_DEPTH)
    ) u_log (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(mem_we),
        .in_ready(log_space),
        .in_data({s_q.p2.addr, dq_in}),
        .out_valid(log_valid),
        .out_ready(log_ready),
        .out_data(log_data)
    );

    // ==========================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    logic ld_rd;
    logic ld_wr;
    logic ld_off;
    assign ld_rd = en && !advance_or_load && sel && read_not_write;
    assign ld_wr = en && !advance_or_load && sel && !read_not_write;
    assign ld_off = en && !advance_or_load && !sel;

    sequence rd_load_s;
        ld_rd;
    endsequence

    sequence two_en_s;
        en [*2];
    endsequence

    hold_on_suspend_a: assert property (!en |=> $stable(dq_out) && $stable(s_q.oe))
        else $error("Output changed on a suspended edge.");
    read_stream_a: assert property (rd_load_s ##1 rd_load_s ##1 rd_load_s |=> s_q.oe)
        else $error("Back-to-back reads left an idle output cycle.");
    write_release_a: assert property (ld_wr ##1 two_en_s |=> !s_q.oe)
        else $error("Bus driven during a write data cycle.");
    read_after_stop_a: assert property (rd_load_s ##1 ld_off ##1 en |=> s_q.oe)
        else $error("Deselect cancelled a pending read.");
    suspend_latency_a: assert property (
        rd_load_s ##1 !en ##1 en ##1 !en [*2] ##1 en |=> s_q.oe)
        else $error("Read latency wrong across suspended edges.");
    write_store_a: assert property (ld_wr ##1 two_en_s |-> mem_we)
        else $error("Write data not stored two enabled edges after load.");
    write_desel_a: assert property (ld_wr ##1 ld_off ##1 en |-> mem_we)
        else $error("Write lost behind a deselect.");
    burst_wrap_a: assert property (
        en && advance_or_load && s_q.mode != SPZ_IDLE && s_q.cnt == 2'h3
        |=> s_q.cnt == 2'h0 && s_q.p1.addr == s_q.base)
        else $error("Burst counter did not wrap to the start address.");
    burst_dir_a: assert property (
        en && advance_or_load && s_q.mode != SPZ_IDLE
        |=> s_q.p1.wr == ($past(s_q.mode) == SPZ_WRITE))
        else $error("Burst direction followed the read/write pin.");
    stop_burst_a: assert property (ld_off |=> s_q.mode == SPZ_IDLE)
        else $error("Deselect did not end the burst.");
    oe_force_a: assert property (out_enable_n |-> !dq_oe)
        else $error("Bus driven while output enable is high.");
    reset_release_a: assert property (@(posedge sys_clk) disable iff (1'b0)
        rst |=> !dq_oe)
        else $error("Bus driven after a reset edge.");
endmodule : spz_sram_port

/* File: spz_defs.svh */
// Constants for the pipelined zero-turnaround SRAM port.
`ifndef SPZ_DEFS_SVH
`define SPZ_DEFS_SVH
// ==========================================
// Array and bus geometry
`define SPZ_ADDR_W 18
`define SPZ_DATA_W 18
`define SPZ_BYTE_W 9
`define SPZ_BYTES 2
// ==========================================
// Burst geometry and write log
`define SPZ_BURST_W 2
`define SPZ_LOG_DEPTH 32
// ==========================================
// Mode encodings, Gray along idle to read to write
`define SPZ_MODE_IDLE 2'h0
`define SPZ_MODE_READ 2'h1
`define SPZ_MODE_WRITE 2'h3
`endif

/* File: spz_pkg.sv */
// Types shared by the SRAM port and its write log.
`include "spz_defs.svh"
package spz_pkg;
    // Burst mode latched at the load cycle.
    typedef enum logic [1:0] {
        SPZ_IDLE = `SPZ_MODE_IDLE,
        SPZ_READ = `SPZ_MODE_READ,
        SPZ_WRITE = `SPZ_MODE_WRITE
    } spz_mode_t;

    // One memory operation travelling down the two-stage pipeline.
    typedef struct packed {
        logic valid;
        logic wr;
        logic [`SPZ_ADDR_W-1:0] addr;
        logic [`SPZ_BYTES-1:0] bw_n;
    } spz_op_t;
endpackage : spz_pkg

/* File: spz_fifo.sv */
// Parameterised valid/ready FIFO used as the write log buffer.
`timescale 1ns/1ps
`include "spz_defs.svh"
module spz_fifo
    import spz_pkg::*;
#(
    parameter int WIDTH = 36,
    parameter int DEPTH = `SPZ_LOG_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] count;
    } spz_fifo_st_t;

    spz_fifo_st_t s_q;
    spz_fifo_st_t s_d;
    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic push;
    logic pop;

    // Full and empty follow the occupancy count directly.
    assign in_ready = (s_q.count != (PW+1)'(DEPTH));
    assign out_valid = (s_q.count != '0);
    assign out_data = mem_q[s_q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers wrap over a power-of-two depth.
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.count = s_q.count + (PW+1)'(push) - (PW+1)'(pop);
    end

    // State register.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Storage array, written only on an accepted push.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[s_q.wp] <= in_data;
        end
    end
endmodule : spz_fifo

/* File: spz_host_model.sv */
// Host controller model that drives the port's synchronous pins.
`timescale 1ns/1ps
module spz_host_model (
    input wire logic sys_clk,
    output logic [17:0] address,
    output logic read_not_write,
    output logic advance_or_load,
    output logic select_low_a,
    output logic select_low_b,
    output logic select_high,
    output logic clock_enable_n,
    output logic [1:0] byte_write_sel_n,
    output logic [17:0] dq_in
);
    // One cycle: kind 0 load, 1 advance, 2/4/5 deselect by each enable, 3 suspend.
    task automatic cyc(input int k, input int a, input logic rnw, input logic [1:0] bw,
                       input logic wv, input int wd);
        @(posedge sys_clk);
        #1;
        clock_enable_n = (k == 3);
        advance_or_load = (k == 1);
        select_low_a = (k == 2);
        select_low_b = (k == 4);
        select_high = (k != 5);
        address = (k == 3) ? ~a[17:0] : a[17:0];
        read_not_write = rnw;
        byte_write_sel_n = bw;
        dq_in = wv ? wd[17:0] : ~dq_in;
    endtask : cyc

    // Start deselected with the write data lines driven to zero.
    initial begin
        clock_enable_n = 1'h0;
        advance_or_load = 1'h0;
        select_low_a = 1'h1;
        select_low_b = 1'h0;
        select_high = 1'h1;
        address = 18'h0;
        read_not_write = 1'h1;
        byte_write_sel_n = 2'h3;
        dq_in = 18'h0;
    end
endmodule : spz_host_model

/* File: test_spz_sram_port.sv */
// Self-checking testbench for the SRAM port.
`timescale 1ns/1ps
module test_spz_sram_port;
    import spz_pkg::*;
    localparam int LD = 0;
    localparam int AV = 1;
    localparam int DS = 2;
    localparam int SU = 3;
    localparam int DB = 4;
    localparam int DC = 5;
    localparam int Q = 'h40000;
    logic sys_clk, rst, read_not_write, advance_or_load, select_low_a, select_low_b;
    logic select_high, clock_enable_n, burst_order_sel, out_enable_n, dq_oe;
    logic log_valid, log_ready, log_space;
    logic [1:0] byte_write_sel_n;
    logic [17:0] address, dq_in, dq_out;
    logic [35:0] log_data;
    int miscompares = 0, checks = 0, cycles = 0;

    spz_sram_port i_spz_sram_port (.sys_clk, .rst, .address, .read_not_write,
        .advance_or_load, .select_low_a, .select_low_b, .select_high, .clock_enable_n,
        .byte_write_sel_n, .burst_order_sel, .out_enable_n, .dq_in, .dq_out, .dq_oe,
        .log_valid, .log_ready, .log_data, .log_space);
    spz_host_model i_spz_host_model (.sys_clk, .address, .read_not_write,
        .advance_or_load, .select_low_a, .select_low_b, .select_high, .clock_enable_n,
        .byte_write_sel_n, .dq_in);

    // ==========================================
    // Shared tasks.
    task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic complete_run;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task automatic cy(input int k, input int a = 0, input logic rnw = 1,
                      input logic [1:0] bw = 0, input logic wv = 0, input int wd = 0);
        i_spz_host_model.cyc(k, a, rnw, bw, wv, wd);
    endtask : cy

    // Bit 18 of the expected value says the bus must be driven.
    task automatic chk(input int e);
        cmp(dq_oe, e[18]);
        if (e[18])
            cmp(dq_out, e[17:0]);
    endtask : chk

    task automatic wr(input int a, input int d, input logic [1:0] bw);
        cy(LD, a, 0, bw);
        cy(DS);
        cy(DS, 0, 1, 0, 1, d);
    endtask : wr

    task automatic rd(input int a, input int e);
        cy(LD, a);
        cy(DS);
        cy(DS);
        cy(DS);
        chk(Q | e);
    endtask : rd

    // Runs ten cycles and judges the bus from cycle f onwards.
    task automatic seq(input int k[10], input int a[10], input int f, input int e[10]);
        for (int j = 0; j < 10; j++) begin
            cy(k[j], a[j]);
            if (j >= f)
                chk(e[j - f]);
        end
    endtask : seq

    // ==========================================
    // Scenarios.
    task automatic test_write_read;
        wr('h100, 'h2A5A5, 2'h0);
        cy(DS);
        chk(0);
        rd('h100, 'h2A5A5);
        wr('h100, 'h0, 2'h2);
        rd('h100, 'h2A400);
        out_enable_n = 1'h1;
        #1;
        cmp(dq_oe, 0);
        out_enable_n = 1'h0;
        #1;
        chk(Q | 'h2A400);
        // Hold the output enable high across an edge while a word is on the bus.
        out_enable_n = 1'h1;
        cy(DS);
        cmp(dq_oe, 0);
        out_enable_n = 1'h0;
        chk(0);
    endtask : test_write_read

    task automatic test_burst;
        for (int o = 0; o < 2; o++) begin
            burst_order_sel = o[0];
            cy(LD, 'h203, 0);
            cy(AV, 0, 1);
            for (int i = 0; i < 4; i++)
                cy(i < 2 ? AV : DS, 0, 1, 0, 1, 'h1000 + 16 * o + i);
            cy(LD, 'h203);
            for (int j = 1; j < 8; j++) begin
                cy(j < 6 ? AV : DS, 0, 0);
                if (j >= 3)
                    chk(Q | ('h1000 + 16 * o + (j - 3) % 4));
            end
            rd('h200 + 2 * o, 'h1001 + 16 * o);
        end
    endtask : test_burst

    task automatic test_pipe;
        for (int i = 0; i < 4; i++)
            wr('h300 + i, 'h3000 + i, 2'h0);
        seq('{LD, AV, LD, LD, LD, DS, DS, DS, DS, DS}, '{'h300, 0, 'h302, 'h303, 'h300, 0,
            0, 0, 0, 0}, 3, '{Q | 'h3000, Q | 'h3001, Q | 'h3002, Q | 'h3003, Q | 'h3000,
            0, 0, 0, 0, 0});
        seq('{LD, LD, SU, LD, SU, SU, LD, DS, DS, DS}, '{'h303, 'h300, 0, 'h301, 0, 0,
            'h302, 0, 0, 0}, 4, '{Q | 'h3003, Q | 'h3003, Q | 'h3003, Q | 'h3000,
            Q | 'h3001, Q | 'h3002, 0, 0, 0, 0});
        seq('{DB, DC, LD, DB, LD, DC, AV, DS, DS, DS}, '{0, 0, 'h300, 0, 'h301, 0, 0, 0, 0,
            0}, 5, '{Q | 'h3000, 0, Q | 'h3001, 0, 0, 0, 0, 0, 0, 0});
    endtask : test_pipe

    task automatic test_fifo;
        int n;
        n = 0;
        log_ready = 1'h0;
        for (int j = 0; j < 37; j++)
            cy(j < 34 ? LD : DS, 'h400 + j, 0, 0, j >= 2, 'h500 + j - 2);
        cmp({log_valid, log_space}, 2'h2);
        cmp(log_data, {18'h400, 18'h500});
        log_ready = 1'h1;
        // Drain the log and check every entry in write order.
        for (int i = 0; i < 40; i++) begin
            if (log_valid === 1'h1) begin
                cmp(log_data, {18'('h400 + n), 18'('h500 + n)});
                n++;
            end
            @(posedge sys_clk);
            #1;
        end
        cmp(n, 32);
        rd('h421, 'h521);
    endtask : test_fifo

    // ==========================================
    // Clock, hang guard and main sequence.
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            complete_run;
        end
    end

    initial begin
        rst = 1'h1;
        burst_order_sel = 1'h0;
        out_enable_n = 1'h0;
        log_ready = 1'h1;
        @(posedge sys_clk);
        #1;
        cmp(dq_oe, 0);
        repeat (7) @(posedge sys_clk);
        #1;
        rst = 1'h0;
        cmp({dq_oe, log_valid, log_space}, 3'h1);
        test_write_read;
        test_burst;
        test_pipe;
        test_fifo;
        complete_run;
    end
endmodule : test_spz_sram_port
